// ===== logic/dps_buf.v
// ************************************
// two-entry word-pair buffer
// ************************************
module dps_buf #(
  parameter W = 72
) (
  input wire mclk,
  input wire rst,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] ent_r [0:1];
  reg wptr_r;
  reg rptr_r;
  reg [1:0] cnt_r;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  assign in_ready = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data = ent_r[rptr_r];

  always @(posedge mclk) begin
    if (rst) begin
      wptr_r <= 1'b0;
      rptr_r <= 1'b0;
      cnt_r <= 2'h0;
      ent_r[0] <= {W{1'b0}};
      ent_r[1] <= {W{1'b0}};
    end else begin
      if (push) begin
        ent_r[wptr_r] <= in_data;
        wptr_r <= ~wptr_r;
      end
      if (pop) begin
        rptr_r <= ~rptr_r;
      end
      if (push & ~pop) begin
        cnt_r <= cnt_r + 2'h1;
      end else if (pop & ~push) begin
        cnt_r <= cnt_r - 2'h1;
      end
    end
  end
endmodule

// ===== logic/dps_core.v
`include "dps_regs.vh"

// ************************************
// burst sram core, device side
// ************************************
module dps_core (
  input wire mclk,
  input wire rst,
  input wire k,
  input wire k_n,
  input wire c,
  input wire c_n,
  input wire read_req_n,
  input wire write_req_n,
  input wire dll_off_n,
  input wire [`DPS_ADDR_W-1:0] word_addr,
  input wire [`DPS_LANES-1:0] byte_lane_write_n,
  input wire [`DPS_DATA_W-1:0] d,
  output wire [`DPS_DATA_W-1:0] q,
  output wire q_valid,
  output wire echo_strobe,
  output wire echo_strobe_n,
  output wire dll_enabled
);
  localparam SW = 7 + `DPS_ADDR_W + `DPS_LANES + `DPS_DATA_W;
  localparam integer CSTOP_I = `DPS_CSTOP_CYC;
  localparam [`DPS_CSTOP_W-1:0] CSTOP_CYC = CSTOP_I[`DPS_CSTOP_W-1:0];

  // ************************************
  // pin synchronisers
  // ************************************
  wire [SW-1:0] pin_in = {k, k_n, c, c_n, read_req_n, write_req_n, dll_off_n,
    word_addr, byte_lane_write_n, d};
  reg [SW-1:0] sync1_r;
  reg [SW-1:0] sync2_r;
  reg [3:0] clk_prev_r;

  // free-running through reset: no false clock edge on release
  always @(posedge mclk) begin
    sync1_r <= pin_in;
    sync2_r <= sync1_r;
    clk_prev_r <= sync2_r[SW-1:SW-4];
  end

  wire k_s = sync2_r[SW-1];
  wire kn_s = sync2_r[SW-2];
  wire c_s = sync2_r[SW-3];
  wire cn_s = sync2_r[SW-4];
  wire rd_s_n = sync2_r[SW-5];
  wire wr_s_n = sync2_r[SW-6];
  wire dll_s_n = sync2_r[SW-7];
  wire [`DPS_ADDR_W-1:0] addr_s = sync2_r[`DPS_LANES+`DPS_DATA_W +: `DPS_ADDR_W];
  wire [`DPS_LANES-1:0] bw_s_n = sync2_r[`DPS_DATA_W +: `DPS_LANES];
  wire [`DPS_DATA_W-1:0] d_s = sync2_r[`DPS_DATA_W-1:0];

  wire k_rise = k_s & ~clk_prev_r[3];
  wire kn_rise = kn_s & ~clk_prev_r[2];
  wire c_rise = c_s & ~clk_prev_r[1];
  wire cn_rise = cn_s & ~clk_prev_r[0];

  // ************************************
  // output clock source select
  // ************************************
  reg [`DPS_CSTOP_W-1:0] cstop_cnt_r;
  wire use_k = (cstop_cnt_r == CSTOP_CYC);
  wire out_rise = use_k ? k_rise : c_rise;
  wire out_n_rise = use_k ? kn_rise : cn_rise;
  wire out_level = use_k ? k_s : c_s;

  always @(posedge mclk) begin
    if (rst) begin
      cstop_cnt_r <= {`DPS_CSTOP_W{1'b0}};
    end else if (c_s & cn_s) begin
      if (!use_k) begin
        cstop_cnt_r <= cstop_cnt_r + {{(`DPS_CSTOP_W-1){1'b0}}, 1'b1};
      end
    end else begin
      cstop_cnt_r <= {`DPS_CSTOP_W{1'b0}};
    end
  end

  // ************************************
  // storage array
  // ************************************
  reg [`DPS_DATA_W-1:0] mem [0:`DPS_DEPTH-1];

  // ************************************
  // command capture
  // ************************************
  wire buf_in_ready;
  wire buf_out_valid;
  wire [`DPS_PAIR_W-1:0] buf_out_data;
  reg rd_pend_r;
  reg [`DPS_ADDR_W-1:0] raddr_r;
  reg wr_pend_r;
  reg [`DPS_DATA_W-1:0] d0_r;
  reg [`DPS_LANES-1:0] bw0_n_r;
  reg dll_en_r;

  always @(posedge mclk) begin
    if (rst) begin
      rd_pend_r <= 1'b0;
      raddr_r <= {`DPS_ADDR_W{1'b0}};
      wr_pend_r <= 1'b0;
      d0_r <= {`DPS_DATA_W{1'b0}};
      bw0_n_r <= {`DPS_LANES{1'b1}};
      dll_en_r <= 1'b0;
    end else begin
      dll_en_r <= dll_s_n;
      if (k_rise) begin
        wr_pend_r <= ~wr_s_n;
        d0_r <= d_s;
        bw0_n_r <= bw_s_n;
        if (!rd_s_n) begin
          rd_pend_r <= 1'b1;
          raddr_r <= addr_s;
        end
      end else if (kn_rise) begin
        wr_pend_r <= 1'b0;
        if (rd_pend_r & buf_in_ready) begin
          rd_pend_r <= 1'b0;
        end
      end
    end
  end

  // ************************************
  // write merge per lane
  // ************************************
  wire wr_commit = kn_rise & wr_pend_r;
  wire [`DPS_PAIR_W-1:0] wr_old = {mem[{addr_s, 1'b1}], mem[{addr_s, 1'b0}]};
  wire [`DPS_PAIR_W-1:0] wr_new = {d_s, d0_r};
  wire [`DPS_BEATS*`DPS_LANES-1:0] wr_bw_n = {bw_s_n, bw0_n_r};
  wire [`DPS_PAIR_W-1:0] wr_merged;

  genvar gi;
  generate
    for (gi = 0; gi < `DPS_BEATS * `DPS_LANES; gi = gi + 1) begin : g_lane
      assign wr_merged[gi*`DPS_LANE_W +: `DPS_LANE_W] = wr_bw_n[gi] ?
        wr_old[gi*`DPS_LANE_W +: `DPS_LANE_W] :
        wr_new[gi*`DPS_LANE_W +: `DPS_LANE_W];
    end
  endgenerate

  always @(posedge mclk) begin
    if (wr_commit) begin
      mem[{addr_s, 1'b0}] <= wr_merged[`DPS_DATA_W-1:0];
      mem[{addr_s, 1'b1}] <= wr_merged[`DPS_PAIR_W-1:`DPS_DATA_W];
    end
  end

  // ************************************
  // read fetch into buffer
  // ************************************
  wire rd_hit = wr_commit & (raddr_r == addr_s);
  wire [`DPS_PAIR_W-1:0] rd_word = rd_hit ? wr_merged :
    {mem[{raddr_r, 1'b1}], mem[{raddr_r, 1'b0}]};
  wire buf_push = kn_rise & rd_pend_r;
  wire buf_pop = out_n_rise & buf_out_valid;

  dps_buf #(
    .W(`DPS_PAIR_W)
  ) u_buf (
    .mclk(mclk),
    .rst(rst),
    .in_valid(buf_push),
    .in_ready(buf_in_ready),
    .in_data(rd_word),
    .out_valid(buf_out_valid),
    .out_ready(out_n_rise),
    .out_data(buf_out_data)
  );

  // ************************************
  // read output beats and echo
  // ************************************
  reg [`DPS_DATA_W-1:0] q_r;
  reg [`DPS_DATA_W-1:0] beat1_r;
  reg beat1_pend_r;
  reg q_valid_r;
  reg echo_r;
  reg echo_n_r;

  always @(posedge mclk) begin
    if (rst) begin
      q_r <= {`DPS_DATA_W{1'b0}};
      beat1_r <= {`DPS_DATA_W{1'b0}};
      beat1_pend_r <= 1'b0;
      q_valid_r <= 1'b0;
      echo_r <= 1'b0;
      echo_n_r <= 1'b1;
    end else begin
      echo_r <= out_level;
      echo_n_r <= ~out_level;
      if (buf_pop) begin
        q_r <= buf_out_data[`DPS_DATA_W-1:0];
        beat1_r <= buf_out_data[`DPS_PAIR_W-1:`DPS_DATA_W];
        beat1_pend_r <= 1'b1;
        q_valid_r <= 1'b1;
      end else if (out_n_rise) begin
        q_valid_r <= 1'b0;
      end else if (out_rise & beat1_pend_r) begin
        q_r <= beat1_r;
        beat1_pend_r <= 1'b0;
      end
    end
  end

  assign q = q_r;
  assign q_valid = q_valid_r;
  assign echo_strobe = echo_r;
  assign echo_strobe_n = echo_n_r;
  assign dll_enabled = dll_en_r;
endmodule

// ===== logic/dps_regs.vh
// How it works
// - each address carries exactly two data beats
// - read and write data on separate ports
// - command clock rise starts every operation
// - command rise takes read, write, strobes, beat0
// - complement rise takes write address, beat1
// - per-beat byte strobes gate each lane
// - first write beat held until address arrives
// - read beat0 at second output-complement rise
// - read beat1 at following true output rise
// - output clocks both high: use command clocks
// - echo strobes follow the output clock in use, with or without reads
// - low on dll control disables the loop
`ifndef DPS_REGS_VH
`define DPS_REGS_VH

// ************************************
// organisation
// ************************************
`define DPS_ADDR_W 19
`define DPS_DATA_W 36
`define DPS_LANES 4
`define DPS_LANE_W 9
`define DPS_BEATS 2
`define DPS_PAIR_W 72
`define DPS_DEPTH 1048576

// ************************************
// timing
// ************************************
`define DPS_MCLK_MHZ 100
`define DPS_CSTOP_NS 200
`define DPS_CSTOP_CYC ((`DPS_CSTOP_NS * `DPS_MCLK_MHZ) / 1000)
`define DPS_CSTOP_W 5

`endif

// ===== verification/dps_core_checker.sv
// ************************************
// port checker
// ************************************
module dps_core_checker (
  input wire mclk,
  input wire rst,
  input wire k,
  input wire k_n,
  input wire c,
  input wire c_n,
  input wire read_req_n,
  input wire write_req_n,
  input wire dll_off_n,
  input wire [18:0] word_addr,
  input wire [3:0] byte_lane_write_n,
  input wire [35:0] d,
  input wire [35:0] q,
  input wire q_valid,
  input wire echo_strobe,
  input wire echo_strobe_n,
  input wire dll_enabled
);
  reg [5:0] since_rd_r;
  reg [5:0] echo_run_r;
  reg echo_last_r;
  always @(posedge mclk) begin
    echo_last_r <= echo_strobe;
    if (rst) since_rd_r <= 6'h3F;
    else if (!read_req_n) since_rd_r <= 6'h00;
    else if (since_rd_r != 6'h3F) since_rd_r <= since_rd_r + 6'h01;
    if (rst || echo_strobe != echo_last_r) echo_run_r <= 6'h00;
    else if (echo_run_r != 6'h3F) echo_run_r <= echo_run_r + 6'h01;
  end
  default clocking dck @(posedge mclk); endclocking
  default disable iff (rst);
  rst_quiet_a: assert property (disable iff (1'b0) rst |=> !q_valid && !echo_strobe &&
    echo_strobe_n && !dll_enabled && q == 36'h000000000) else $error("outputs not cleared");
  echo_pair_a: assert property (echo_strobe_n == !echo_strobe)
    else $error("echo pair not complementary");
  dll_off_a: assert property ($fell(dll_off_n) |-> ##[1:5] !dll_enabled)
    else $error("loop not disabled");
  dll_on_a: assert property ($rose(dll_off_n) |-> ##[1:5] dll_enabled)
    else $error("loop not enabled");
  read_cause_a: assert property (
    $rose(q_valid) |-> since_rd_r >= 6'h0C && since_rd_r <= 6'h1E)
    else $error("read data without timely request");
  beat_hold_a: assert property (q_valid && $changed(q) |=> $stable(q) [*4])
    else $error("read beat held too briefly");
  burst_span_a: assert property ($rose(q_valid) |-> q_valid [*8])
    else $error("burst shorter than two beats");
  echo_live_a: assert property (echo_run_r < 6'h30)
    else $error("echo strobe stalled");
endmodule
bind dps_core dps_core_checker dps_core_checker_i (.mclk, .rst, .k, .k_n, .c, .c_n,
  .read_req_n, .write_req_n, .dll_off_n, .word_addr, .byte_lane_write_n, .d, .q, .q_valid,
  .echo_strobe, .echo_strobe_n, .dll_enabled);

// ===== verification/dps_ctl.sv
// ************************************
// controller clock source
// ************************************
module dps_ctl (
  output logic k,
  output logic k_n,
  output logic c,
  output logic c_n,
  input wire logic cstop
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    k = 1'b0;
    #3.3;
    forever #62.5 k = ~k;
  end
  assign k_n = ~k;
  assign c = cstop | k;
  assign c_n = cstop | ~k;
endmodule

// ===== verification/dual_port_ddr_burst_sram_interface_bench.sv
// ************************************
// bench
// ************************************
module dual_port_ddr_burst_sram_interface_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0, rst = 1'b1, read_req_n = 1'b1, write_req_n = 1'b1, dll_off_n = 1'b1;
  logic cstop = 1'b0, k, k_n, c, c_n, q_valid, echo_strobe, echo_strobe_n, dll_enabled;
  logic [18:0] word_addr = 19'h00000;
  logic [3:0] byte_lane_write_n = 4'hF;
  logic [35:0] d = 36'h000000000, q;
  int num_errors = 0, check_count = 0, cycles = 0;
  dps_ctl dps_ctl_i (.k, .k_n, .c, .c_n, .cstop);
  dps_core dps_core_i (.mclk, .rst, .k, .k_n, .c, .c_n, .read_req_n, .write_req_n, .dll_off_n,
    .word_addr, .byte_lane_write_n, .d, .q, .q_valid, .echo_strobe, .echo_strobe_n, .dll_enabled);
  initial forever #5 mclk = ~mclk;
  task automatic stop_test;
    if (num_errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      stop_test;
    end
  end
  task automatic check(input logic [35:0] seen, input logic [35:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [35:0] merge(input logic [35:0] old, input logic [35:0] nw,
    input logic [3:0] bw_n);
    for (int i = 0; i < 4; i++) begin
      if (!bw_n[i]) old[9*i +: 9] = nw[9*i +: 9];
    end
    return old;
  endfunction
  // one command clock cycle: k-phase then k_n-phase values
  task automatic op(input logic r, input logic w, input logic [18:0] ra, input logic [18:0] wa,
    input logic [3:0] b0, input logic [3:0] b1, input logic [35:0] d0, input logic [35:0] d1);
    @(posedge k_n);
    repeat (2) @(posedge mclk);
    read_req_n <= ~r;
    write_req_n <= ~w;
    word_addr <= ra;
    byte_lane_write_n <= b0;
    d <= d0;
    @(posedge k);
    repeat (2) @(posedge mclk);
    read_req_n <= 1'b1;
    write_req_n <= 1'b1;
    word_addr <= wa;
    byte_lane_write_n <= b1;
    d <= d1;
  endtask
  task automatic rd_check(input logic [35:0] e0, input logic [35:0] e1);
    int n;
    n = 0;
    while (q_valid !== 1'b1 && n < 60) begin
      @(posedge mclk) #1;
      n++;
    end
    check({35'h0, q_valid}, 36'h1, "read valid");
    check(q, e0, "first beat");
    repeat (9) @(posedge mclk);
    #1;
    check({35'h0, q_valid}, 36'h1, "read valid beat1");
    check(q, e1, "second beat");
  endtask
  task automatic s_write_read;
    op(1'b0, 1'b1, 19'h00000, 19'h5A5A5, 4'h0, 4'h0, 36'h123456789, 36'hFEDCBA987);
    op(1'b1, 1'b0, 19'h5A5A5, 19'h00000, 4'hF, 4'hF, 36'h0, 36'h0);
    rd_check(36'h123456789, 36'hFEDCBA987);
  endtask
  task automatic s_lanes;
    op(1'b0, 1'b1, 19'h00000, 19'h5A5A5, 4'h5, 4'hA, 36'hAAAAAAAAA, 36'h555555555);
    op(1'b1, 1'b0, 19'h5A5A5, 19'h00000, 4'hF, 4'hF, 36'h0, 36'h0);
    rd_check(merge(36'h123456789, 36'hAAAAAAAAA, 4'h5),
      merge(36'hFEDCBA987, 36'h555555555, 4'hA));
  endtask
  task automatic s_same_edge;
    op(1'b1, 1'b1, 19'h5A5A5, 19'h5A5A5, 4'h0, 4'h0, 36'h00F0F0F0F, 36'h3C3C3C3C3);
    rd_check(36'h00F0F0F0F, 36'h3C3C3C3C3);
  endtask
  task automatic s_clock_stop;
    @(posedge mclk);
    cstop <= 1'b1;
    repeat (30) @(posedge mclk);
    op(1'b1, 1'b0, 19'h5A5A5, 19'h00000, 4'hF, 4'hF, 36'h0, 36'h0);
    rd_check(36'h00F0F0F0F, 36'h3C3C3C3C3);
    @(posedge mclk);
    cstop <= 1'b0;
  endtask
  task automatic s_dll;
    @(posedge mclk);
    dll_off_n <= 1'b0;
    repeat (6) @(posedge mclk);
    #1;
    check({35'h0, dll_enabled}, 36'h0, "loop off");
    @(posedge mclk);
    dll_off_n <= 1'b1;
    repeat (6) @(posedge mclk);
    #1;
    check({35'h0, dll_enabled}, 36'h1, "loop on");
  endtask
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    s_write_read;
    s_lanes;
    s_same_edge;
    s_clock_stop;
    s_dll;
    stop_test;
  end
endmodule
